// File: rtl/touch_defines.svh
`ifndef TOUCH_DEFINES_SVH
`define TOUCH_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_VARIATION_LIMIT    8'h26
`define ADDR_DRIFT_STEP         8'h27
`define ADDR_CONSECUTIVE_COUNT  8'h28
`define ADDR_PAD0_TOUCH_TRIP    8'h29
`define ADDR_PAD0_RELEASE_TRIP  8'h2a
`define ADDR_PAD1_TOUCH_TRIP    8'h2b
`define ADDR_PAD1_RELEASE_TRIP  8'h2c
`define ADDR_PAD2_TOUCH_TRIP    8'h2d
`define ADDR_PAD2_RELEASE_TRIP  8'h2e

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define VARIATION_LIMIT_MSB     5
`define DRIFT_STEP_MSB          5
`define CONSECUTIVE_COUNT_MSB   3
`define TRIP_MSB                7

// ----------------------------------------------------------------------
// Reset values and consecutive-count code constants
// ----------------------------------------------------------------------
`define RST_VARIATION_LIMIT     6'h01
`define RST_DRIFT_STEP          6'h01
`define RST_CONSECUTIVE_COUNT   4'h0
`define RST_TRIP                8'h00
`define CODE_COUNT_TOP          4'hf
`define COUNT_AT_TOP            5'h0f

`endif

// File: rtl/touch_pkg.sv
package touch_pkg;

    typedef struct packed {
        logic [5:0] variation_limit;
        logic [5:0] drift_step;
        logic [3:0] consecutive_count;
    } baseline_cfg_s;

    typedef struct packed {
        logic [7:0] touch_trip;
        logic [7:0] release_trip;
    } pad_trip_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } sample_s;

    typedef enum logic {
        PAD_RELEASED,
        PAD_TOUCHED
    } pad_state_e;

endpackage

// File: rtl/touch_pad_channel.sv
`timescale 1ns/10ps
`default_nettype none
`include "touch_defines.svh"

module touch_pad_channel
    import touch_pkg::*;
#(
    parameter int DATA_W = 16
)
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire touch_pkg::baseline_cfg_s cfg,
    input  wire touch_pkg::pad_trip_s     trip,
    input  wire logic                trips_all_zero,
    input  wire logic                sample_valid,
    input  wire logic [DATA_W-1:0]   sample_data,
    output logic [DATA_W-1:0]        baseline_reg,
    output logic                     touched_reg,
    output logic                     event_reg
);
    import touch_pkg::*;

    logic [4:0]        run_reg;
    logic              primed_reg;
    logic              below;
    logic [DATA_W-1:0] diff;
    logic [DATA_W-1:0] delta;
    logic              over_limit;
    logic [4:0]        need;
    logic              run_done;
    logic [4:0]        run_next;
    logic [DATA_W-1:0] step;
    logic              touch_hit;
    logic              release_hit;

    always_comb
    begin
        below = sample_data < baseline_reg;
        diff  = below ? baseline_reg - sample_data : '0;
        delta = below ? baseline_reg - sample_data
                      : sample_data - baseline_reg;
        over_limit = delta > DATA_W'(cfg.variation_limit);
        // Code 15 yields 15 samples, not 16
        need = (cfg.consecutive_count == `CODE_COUNT_TOP) ? `COUNT_AT_TOP
             : 5'(cfg.consecutive_count) + 5'h01;              // [R6]
        run_next = over_limit ? run_reg + 5'h01 : 5'h00;
        run_done = over_limit && (run_next >= need);           // [R5]
        step = DATA_W'(cfg.drift_step);
        if (step > delta)
        begin
            step = delta;
        end
        // Touch lowers counts: only data under baseline can trip
        touch_hit = !trips_all_zero && !touched_reg
                  && (diff > DATA_W'(trip.touch_trip));        // [R7] [R8] [R10] [R17]
        release_hit = touched_reg
                    && (diff < DATA_W'(trip.release_trip));    // [R11]
    end

    // ------------------------------------------------------------------
    // Baseline tracking
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            baseline_reg <= '0;
            primed_reg   <= 1'b0;
            run_reg      <= 5'h00;
        end
        else if (sample_valid)
        begin
            if (!primed_reg)
            begin
                // First sample seeds the baseline, avoiding a false touch
                baseline_reg <= sample_data;
                primed_reg   <= 1'b1;
                run_reg      <= 5'h00;
            end
            else if (touched_reg || touch_hit)
            begin
                run_reg <= 5'h00;                              // [R9] [R16]
            end
            else if (run_done)
            begin
                baseline_reg <= below ? baseline_reg - step
                                      : baseline_reg + step;   // [R3] [R18]
                run_reg      <= 5'h00;
            end
            else
            begin
                run_reg <= run_next;                           // [R1] [R18]
            end
        end
    end

    // ------------------------------------------------------------------
    // Touch state
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            touched_reg <= 1'b0;
            event_reg   <= 1'b0;
        end
        else
        begin
            event_reg <= 1'b0;
            if (sample_valid && primed_reg && (touch_hit || release_hit))
            begin
                touched_reg <= touch_hit;                      // [R9] [R12]
                event_reg   <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// File: rtl/touch_baseline_threshold_detect.sv
// Overview of operation
// [R1] Register 0x26 bits 5:0 hold the largest variation passed to baseline.
// [R2] Host never writes zero to the variation limit; 1..63 are direct.
// [R3] Register 0x27 bits 5:0 hold the baseline drift step.
// [R4] Host never writes zero to the drift step; 1..63 are direct.
// [R5] Register 0x28 bits 3:0 hold consecutive samples needed over limit.
// [R6] Count code 0 means one, 1 means two, 15 means fifteen.
// [R7] Touch lowers counts: data falling below baseline is touch direction.
// [R8] Touch declared when baseline minus data significantly exceeds threshold.
// [R9] Touch freezes baseline, raises interrupt, sets pad status bit.
// [R10] Each pad has its own touch threshold.
// [R11] Each pad has its own release threshold.
// [R12] Release unfreezes baseline, raises interrupt, clears status bit.
// [R13] Touch thresholds for pads 0,1,2 at 0x29, 0x2B, 0x2D.
// [R14] Release thresholds for pads 0,1,2 at 0x2A, 0x2C, 0x2E.
// [R15] Each threshold is a full eight-bit field, 0 to 255.
// [R16] Baseline holds while touched and tracks again after release.
// [R17] All touch thresholds zero disables detection; baseline only filters.
// [R18] Untouched baseline steps toward data after enough over-limit samples.
// [R19] Baseline, counters and touch state are independent per pad.
`timescale 1ns/10ps
`default_nettype none
`include "touch_defines.svh"

module touch_baseline_threshold_detect
    import touch_pkg::*;
#(
    parameter int PADS   = 3,
    parameter int DATA_W = 16
)
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    output logic [7:0]                  reg_rdata_reg,
    output logic                        reg_hit_reg,
    input  wire logic [PADS-1:0]        sample_valid,
    input  wire logic [PADS*DATA_W-1:0] sample_data,
    output logic [PADS*DATA_W-1:0]      baseline_data,
    output logic [PADS-1:0]             touch_status,
    output logic                        touch_event_reg
);
    import touch_pkg::*;

    localparam int TRIP_PADS = 3;

    baseline_cfg_s          cfg_reg;
    pad_trip_s              trip_reg [TRIP_PADS];
    logic                   trips_all_zero;
    logic [PADS-1:0]        pad_event;
    logic [PADS-1:0]        pad_touched;
    logic [7:0]             rdata_next;
    logic                   hit_next;

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Reset values: limit and step 1, count code 0 (one sample); host programs real settings
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cfg_reg.variation_limit   <= `RST_VARIATION_LIMIT;
            cfg_reg.drift_step        <= `RST_DRIFT_STEP;
            cfg_reg.consecutive_count <= `RST_CONSECUTIVE_COUNT;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `ADDR_VARIATION_LIMIT)
            begin
                cfg_reg.variation_limit <=
                    reg_wdata[`VARIATION_LIMIT_MSB:0];          // [R1] [R2]
            end
            else if (reg_addr == `ADDR_DRIFT_STEP)
            begin
                cfg_reg.drift_step <= reg_wdata[`DRIFT_STEP_MSB:0]; // [R3] [R4]
            end
            else if (reg_addr == `ADDR_CONSECUTIVE_COUNT)
            begin
                cfg_reg.consecutive_count <=
                    reg_wdata[`CONSECUTIVE_COUNT_MSB:0];        // [R5]
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < TRIP_PADS; i++)
            begin
                trip_reg[i] <= '{`RST_TRIP, `RST_TRIP};
            end
        end
        else if (reg_wr)
        begin
            if (reg_addr == `ADDR_PAD0_TOUCH_TRIP)
            begin
                trip_reg[0].touch_trip <= reg_wdata;            // [R13] [R15]
            end
            else if (reg_addr == `ADDR_PAD0_RELEASE_TRIP)
            begin
                trip_reg[0].release_trip <= reg_wdata;          // [R14] [R15]
            end
            else if (reg_addr == `ADDR_PAD1_TOUCH_TRIP)
            begin
                trip_reg[1].touch_trip <= reg_wdata;            // [R13]
            end
            else if (reg_addr == `ADDR_PAD1_RELEASE_TRIP)
            begin
                trip_reg[1].release_trip <= reg_wdata;          // [R14]
            end
            else if (reg_addr == `ADDR_PAD2_TOUCH_TRIP)
            begin
                trip_reg[2].touch_trip <= reg_wdata;            // [R13]
            end
            else if (reg_addr == `ADDR_PAD2_RELEASE_TRIP)
            begin
                trip_reg[2].release_trip <= reg_wdata;          // [R14]
            end
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    always_comb
    begin
        rdata_next = 8'h00;
        hit_next   = 1'b1;
        if (reg_addr == `ADDR_VARIATION_LIMIT)
        begin
            rdata_next = {2'h0, cfg_reg.variation_limit};
        end
        else if (reg_addr == `ADDR_DRIFT_STEP)
        begin
            rdata_next = {2'h0, cfg_reg.drift_step};
        end
        else if (reg_addr == `ADDR_CONSECUTIVE_COUNT)
        begin
            rdata_next = {4'h0, cfg_reg.consecutive_count};
        end
        else if (reg_addr == `ADDR_PAD0_TOUCH_TRIP)
        begin
            rdata_next = trip_reg[0].touch_trip;
        end
        else if (reg_addr == `ADDR_PAD0_RELEASE_TRIP)
        begin
            rdata_next = trip_reg[0].release_trip;
        end
        else if (reg_addr == `ADDR_PAD1_TOUCH_TRIP)
        begin
            rdata_next = trip_reg[1].touch_trip;
        end
        else if (reg_addr == `ADDR_PAD1_RELEASE_TRIP)
        begin
            rdata_next = trip_reg[1].release_trip;
        end
        else if (reg_addr == `ADDR_PAD2_TOUCH_TRIP)
        begin
            rdata_next = trip_reg[2].touch_trip;
        end
        else if (reg_addr == `ADDR_PAD2_RELEASE_TRIP)
        begin
            rdata_next = trip_reg[2].release_trip;
        end
        else
        begin
            hit_next = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            reg_rdata_reg <= 8'h00;
            reg_hit_reg   <= 1'b0;
        end
        else if (reg_rd)
        begin
            reg_rdata_reg <= rdata_next;
            reg_hit_reg   <= hit_next;
        end
    end

    // ------------------------------------------------------------------
    // Per-pad detection
    // ------------------------------------------------------------------
    always_comb
    begin
        trips_all_zero = 1'b1;
        for (int i = 0; i < TRIP_PADS; i++)
        begin
            if (trip_reg[i].touch_trip != 8'h00)
            begin
                trips_all_zero = 1'b0;                          // [R17]
            end
        end
    end

    // Pads beyond the third reuse the last threshold pair
    for (genvar p = 0; p < PADS; p++)
    begin : g_pad
        localparam int TI = (p < TRIP_PADS) ? p : TRIP_PADS - 1;
        touch_pad_channel #(
            .DATA_W (DATA_W)
        ) u_chan (
            .clk            (clk),
            .rst            (rst),
            .cfg            (cfg_reg),
            .trip           (trip_reg[TI]),
            .trips_all_zero (trips_all_zero),
            .sample_valid   (sample_valid[p]),
            .sample_data    (sample_data[p*DATA_W +: DATA_W]),
            .baseline_reg   (baseline_data[p*DATA_W +: DATA_W]),
            .touched_reg    (pad_touched[p]),
            .event_reg      (pad_event[p])
        );                                                      // [R19]
    end

    assign touch_status = pad_touched;                          // [R9] [R12]

    // ------------------------------------------------------------------
    // Event pulse toward the interrupt logic
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            touch_event_reg <= 1'b0;
        end
        else
        begin
            touch_event_reg <= |pad_event;                      // [R9] [R12]
        end
    end

endmodule
`default_nettype wire

// File: verification/touch_baseline_threshold_detect_chk.sv
`timescale 1ns/10ps
`default_nettype none

module touch_baseline_threshold_detect_chk
#(
    parameter int PADS   = 3,
    parameter int DATA_W = 16
)
(
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [7:0]             reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic [7:0]             reg_rdata_reg,
    input wire logic                   reg_hit_reg,
    input wire logic [PADS-1:0]        sample_valid,
    input wire logic [PADS*DATA_W-1:0] sample_data,
    input wire logic [PADS*DATA_W-1:0] baseline_data,
    input wire logic [PADS-1:0]        touch_status,
    input wire logic                   touch_event_reg
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic mapped;
    assign mapped = reg_addr >= 8'h26 && reg_addr <= 8'h2e;

    // ------------------------------------------------------------
    // Register side
    // ------------------------------------------------------------
    // Host leaves one idle cycle between a write and the read behind it
    sequence s_trip_wr_rd;
        reg_wr && !reg_rd && reg_addr >= 8'h29 && reg_addr <= 8'h2e
        ##1 !reg_wr
        ##1 reg_rd && !reg_wr && reg_addr == $past(reg_addr, 2);
    endsequence

    a_trip_full_byte: assert property (
        s_trip_wr_rd |=> reg_rdata_reg == $past(reg_wdata, 3))
        else $error("trip byte not read back whole");
    a_mapped_hit: assert property (
        reg_rd && mapped |=> reg_hit_reg)
        else $error("mapped read not flagged");
    a_unmapped_zero: assert property (
        reg_rd && !mapped |=> !reg_hit_reg && reg_rdata_reg == 8'h00)
        else $error("unmapped read not empty");
    a_six_bit_fields: assert property (
        reg_rd && (reg_addr == 8'h26 || reg_addr == 8'h27)
        |=> reg_rdata_reg[7:6] == 2'b00)
        else $error("six-bit field shows upper bits");
    a_count_field: assert property (
        reg_rd && reg_addr == 8'h28 |=> reg_rdata_reg[7:4] == 4'h0)
        else $error("count field shows upper bits");

    // ------------------------------------------------------------
    // Detection side
    // ------------------------------------------------------------
    a_event_follows: assert property (
        $changed(touch_status) |=> touch_event_reg)
        else $error("status change without event");
    a_event_cause: assert property (
        touch_event_reg |-> $past(touch_status) != $past(touch_status, 2))
        else $error("event without status change");
    a_status_cause: assert property (
        ((touch_status ^ $past(touch_status)) & ~$past(sample_valid)) == '0)
        else $error("status moved without own sample");

    for (genvar p = 0; p < PADS; p++)
    begin : g_pad
        a_frozen_touch: assert property (
            $past(touch_status[p]) && touch_status[p]
            |-> $stable(baseline_data[p*DATA_W +: DATA_W]))
            else $error("baseline moved while touched");
        a_touch_below: assert property (
            $rose(touch_status[p])
            |-> $past(sample_data[p*DATA_W +: DATA_W])
            < $past(baseline_data[p*DATA_W +: DATA_W]))
            else $error("touch without data below baseline");
    end
endmodule

bind touch_baseline_threshold_detect touch_baseline_threshold_detect_chk
    #(.PADS(PADS), .DATA_W(DATA_W)) i_touch_baseline_threshold_detect_chk (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_reg(reg_rdata_reg), .reg_hit_reg(reg_hit_reg),
    .sample_valid(sample_valid), .sample_data(sample_data),
    .baseline_data(baseline_data), .touch_status(touch_status),
    .touch_event_reg(touch_event_reg));

`default_nettype wire

// File: verification/host_model.sv
`timescale 1ns/10ps
`default_nettype none

module host_model
(
    input  wire logic  clk,
    output logic       reg_wr,
    output logic       reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial
    begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // Released lines show the inverse so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if ((a == 8'h26 || a == 8'h27) && v[5:0] == 6'h00)
            v[0] = 1'b1;
        @(posedge clk);
        #1;
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = v;
        @(posedge clk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~v;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        #1;
        reg_rd   = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
    endtask
endmodule

`default_nettype wire

// File: verification/touch_baseline_threshold_detect_tb.sv
`timescale 1ns/10ps
`default_nettype none

module touch_baseline_threshold_detect_tb;
    localparam int PADS = 3;
    localparam int DW   = 16;

    logic               clk;
    logic               rst;
    logic               reg_wr;
    logic               reg_rd;
    logic [7:0]         reg_addr;
    logic [7:0]         reg_wdata;
    logic [7:0]         reg_rdata_reg;
    logic               reg_hit_reg;
    logic [PADS-1:0]    sample_valid;
    logic [PADS*DW-1:0] sample_data;
    logic [PADS*DW-1:0] baseline_data;
    logic [PADS-1:0]    touch_status;
    logic               touch_event_reg;
    logic               rd_seen;
    int                 n_errors;
    int                 comparisons;
    int                 cycles;
    logic [15:0]        rd_q[$];
    logic [15:0]        ev_q[$];
    logic [3:0]         codes[3] = '{4'h0, 4'h1, 4'hf};

    host_model i_host_model (
        .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    touch_baseline_threshold_detect #(.PADS(PADS), .DATA_W(DW))
        i_touch_baseline_threshold_detect (
        .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_reg(reg_rdata_reg), .reg_hit_reg(reg_hit_reg),
        .sample_valid(sample_valid), .sample_data(sample_data),
        .baseline_data(baseline_data), .touch_status(touch_status),
        .touch_event_reg(touch_event_reg));

    always #5 clk = ~clk;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic send(input int p, input logic [15:0] d);
        @(posedge clk);
        #1;
        sample_valid[p]         = 1'b1;
        sample_data[p*DW +: DW] = d;
        @(posedge clk);
        #1;
        sample_valid[p]         = 1'b0;
        sample_data[p*DW +: DW] = ~d;
    endtask

    // ------------------------------------------------------------
    // Result watcher: an empty queue expects x, so a stray result fails
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        rd_seen = reg_rd;
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            report_and_stop();
        end
        #2;
        if (rd_seen && !rst)
            chk({7'h00, reg_hit_reg, reg_rdata_reg},
                rd_q.size() > 0 ? rd_q.pop_front() : 16'hxxxx);
        if (touch_event_reg === 1'b1)
            chk({13'h0000, touch_status},
                ev_q.size() > 0 ? ev_q.pop_front() : 16'hxxxx);
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0]  v;
        logic [15:0] b;
        int          need;
        clk          = 1'b0;
        rst          = 1'b1;
        sample_valid = '0;
        sample_data  = '0;
        n_errors     = 0;
        comparisons  = 0;
        cycles       = 0;
        void'($urandom(32'h8bd5751b));
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        for (int a = 8'h25; a <= 8'h2f; a++)
        begin
            v = (a == 8'h26 || a == 8'h27) ? 8'h01 : 8'h00;
            rd_q.push_back({7'h00, 1'(a >= 8'h26 && a <= 8'h2e), v});
            i_host_model.rd(8'(a));
        end
        for (int a = 8'h26; a <= 8'h2e; a++)
        begin
            v = 8'($urandom()) | 8'h01;
            i_host_model.wr(8'(a), v);
            if (a < 8'h28)
                v = v & 8'h3f;
            else if (a == 8'h28)
                v = v & 8'h0f;
            rd_q.push_back({8'h01, v});
            i_host_model.rd(8'(a));
        end
        // Data above baseline never counts as touch direction
        i_host_model.wr(8'h26, 8'h04);
        i_host_model.wr(8'h27, 8'h03);
        send(0, 16'd100);
        b = 16'd100;
        foreach (codes[i])
        begin
            i_host_model.wr(8'h28, {4'h0, codes[i]});
            need = codes[i] == 4'hf ? 15 : int'(codes[i]) + 1;
            repeat (need - 1) send(0, b + 16'd50);
            chk(baseline_data[15:0], b);
            send(0, b + 16'd50);
            b = b + 16'd3;
            chk(baseline_data[15:0], b);
        end
        i_host_model.wr(8'h28, 8'h01);
        send(0, b + 16'd50);
        send(0, b + 16'd2);
        send(0, b + 16'd50);
        chk(baseline_data[15:0], b);
        chk(baseline_data[47:32], 16'd0);
        // Pad one trips at its own levels; others sit at full scale
        i_host_model.wr(8'h26, 8'h3f);
        i_host_model.wr(8'h28, 8'h00);
        i_host_model.wr(8'h29, 8'hff);
        i_host_model.wr(8'h2d, 8'hff);
        i_host_model.wr(8'h2b, 8'h14);
        i_host_model.wr(8'h2c, 8'h0a);
        send(1, 16'd1000);
        send(1, 16'd980);
        chk({13'h0000, touch_status}, 16'h0000);
        ev_q.push_back(16'h0002);
        send(1, 16'd979);
        send(0, 16'd0);
        repeat (3) send(1, 16'd900);
        chk(baseline_data[31:16], 16'd1000);
        send(1, 16'd990);
        chk({13'h0000, touch_status}, 16'h0002);
        ev_q.push_back(16'h0000);
        send(1, 16'd991);
        send(1, 16'd1100);
        chk(baseline_data[31:16], 16'd1003);
        // All touch trips at zero: stage only filters
        i_host_model.wr(8'h29, 8'h00);
        i_host_model.wr(8'h2b, 8'h00);
        i_host_model.wr(8'h2d, 8'h00);
        i_host_model.wr(8'h27, 8'h05);
        send(1, 16'd500);
        chk(baseline_data[31:16], 16'd998);
        repeat (4) @(posedge clk);
        #1;
        chk(16'(rd_q.size() + ev_q.size()), 16'd0);
        report_and_stop();
    end
endmodule

`default_nettype wire
